// ### hdl/dsr_regs.svh
// dual result serial readout: timing counts, widths and reset values
// assumes a 20 MHz system clock on both ends of the link
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

`define DSR_RES_BITS 14
`define DSR_SLOT_BITS 14
`define DSR_FRAME_BITS (`DSR_RES_BITS + `DSR_SLOT_BITS)
`define DSR_CNT_BITS 11
`define DSR_BIT_BITS 5
`define DSR_CLK_PERIOD_NS 50
`define DSR_CONV_TIME_NS 1250
`define DSR_CONV_CYCLES ((`DSR_CONV_TIME_NS + `DSR_CLK_PERIOD_NS - 1) / `DSR_CLK_PERIOD_NS)
`define DSR_POWERUP_TIME_US 70
`define DSR_POWERUP_CYCLES ((`DSR_POWERUP_TIME_US * 1000 + `DSR_CLK_PERIOD_NS - 1) / `DSR_CLK_PERIOD_NS)
`define DSR_START_LOW_CYCLES 4
`define DSR_SCLK_HALF_CYCLES 4
`define DSR_SAMPLE_DELAY_CYCLES 2
`define DSR_FIFO_DEPTH 8
`define DSR_SYNC_HIGH 3'h7
`define DSR_SYNC_LOW 2'h0

`endif

// ### hdl/dsr_pkg.sv
// dual result serial readout: shared types and state records
// assumes dsr_regs.svh is on the include path
package dsr_pkg;
`include "dsr_regs.svh"

    typedef logic [`DSR_RES_BITS-1:0] dsr_res_t;
    typedef logic [`DSR_FRAME_BITS-1:0] dsr_frame_t;
    typedef logic [`DSR_CNT_BITS-1:0] dsr_cnt_t;
    typedef logic [`DSR_BIT_BITS-1:0] dsr_bit_t;

    typedef enum logic [1:0] {
        DSR_D_READY = 2'b00,
        DSR_D_CONVERT = 2'b01,
        DSR_D_SHUTDOWN = 2'b10
    } dsr_dev_mode_t;

    typedef enum logic [2:0] {
        DSR_H_IDLE = 3'b000,
        DSR_H_CONV = 3'b001,
        DSR_H_READ = 3'b010,
        DSR_H_PUSH_A = 3'b011,
        DSR_H_PUSH_B = 3'b100
    } dsr_host_state_t;

    typedef struct packed {
        logic [2:0] cnv_pipe;
        logic [2:0] cs_pipe;
        logic [2:0] sclk_pipe;
        dsr_dev_mode_t mode;
        dsr_cnt_t cnt;
        dsr_res_t samp_a;
        dsr_res_t samp_b;
        dsr_res_t res_a;
        dsr_res_t res_b;
        dsr_frame_t sr_first;
        dsr_frame_t sr_second;
        logic oe;
        logic busy;
        logic powered_down;
    } dsr_dev_regs_t;

    typedef struct packed {
        dsr_host_state_t state;
        logic conversion_start_n_n;
        logic cs_n;
        logic sclk;
        logic [1:0] busy_pipe;
        logic [1:0] first_pipe;
        logic [1:0] second_pipe;
        logic busy_seen;
        logic sd;
        logic single;
        logic line;
        logic idle;
        dsr_cnt_t cnt;
        dsr_cnt_t pwr;
        dsr_bit_t bits;
        dsr_frame_t acc_first;
        dsr_frame_t acc_second;
    } dsr_host_regs_t;

endpackage : dsr_pkg

// ### hdl/dsr_link_if.sv
// dual result serial readout: the pins between converter and host
// assumes the bench reads each data line directly, without resolving it from its output enable
`timescale 1ns/1ps
`default_nettype none

interface dsr_link_if;
    logic conversion_start_n;
    logic chip_select_n;
    logic serial_clock;
    logic busy;
    logic result_out_first;
    logic result_out_first_oe;
    logic result_out_second;
    logic result_out_second_oe;

    modport device (
        input conversion_start_n,
        input chip_select_n,
        input serial_clock,
        output busy,
        output result_out_first,
        output result_out_first_oe,
        output result_out_second,
        output result_out_second_oe
    );

    modport host (
        output conversion_start_n,
        output chip_select_n,
        output serial_clock,
        input busy,
        input result_out_first,
        input result_out_first_oe,
        input result_out_second,
        input result_out_second_oe
    );
endinterface : dsr_link_if

`default_nettype wire

// ### hdl/dsr_device.sv
// dual result serial readout: converter end (conversion timing, readout)
// assumes link pins are asynchronous to clk_i; samples come from clk_i logic
//
// Behaviour
// - start falling edge converts both channels together
// - busy high until both conversions finish
// - one data output per converter, either usable
// - host drives serial clock and chip select
// - select low enables outputs, shows MSB
// - results go MSB first, 12 or 14 bits; the code sends 14-bit results only
// - later bits advance on serial clock falls
// - host gives at least one result's clocks
// - select rising ends transfer, outputs released
// - further 14 clocks bring other result
// - twelve-bit second result gets two leading zeros; the code has 14-bit results, so the lower slot is never padded
// - clock fall with select fall is ignored
// - early select gives valid MSB at busy fall
// - select tied low keeps outputs always driven
// - next bit on first fall after busy
// - host reads on busy falling edge
// - host samples on falling edge, MSB first
// - start low at busy fall powers down
// - host holds start high 70 us to wake
// - host raises select after a combined read
`timescale 1ns/1ps
`default_nettype none

module dsr_device
    import dsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    dsr_link_if.device link,
    input wire logic [`DSR_RES_BITS-1:0] sample_a_i,
    input wire logic [`DSR_RES_BITS-1:0] sample_b_i,
    output logic powered_down_o
);

    // ************
    // reset image
    // ************

    localparam dsr_dev_regs_t DSR_DEV_RESET = '{
        cnv_pipe: `DSR_SYNC_HIGH,
        cs_pipe: `DSR_SYNC_HIGH,
        sclk_pipe: `DSR_SYNC_HIGH,
        mode: DSR_D_READY,
        cnt: '0,
        samp_a: '0,
        samp_b: '0,
        res_a: '0,
        res_b: '0,
        sr_first: '0,
        sr_second: '0,
        oe: 1'b0,
        busy: 1'b0,
        powered_down: 1'b0
    };

    dsr_dev_regs_t st_reg;
    dsr_dev_regs_t st_next;

    // ************
    // frame builder
    // ************

    // lead result on top, then the other result filling the lower slot
    function automatic dsr_frame_t dsr_build_frame(input dsr_res_t lead, input dsr_res_t tail);
        return {lead, `DSR_SLOT_BITS'(tail)};
    endfunction : dsr_build_frame

    // ************
    // next state
    // ************

    always_comb begin
        logic cnv_fall;
        logic cnv_rise;
        logic cs_low;
        logic cs_fall;
        logic sclk_fall;
        logic done;
        cnv_fall = st_reg.cnv_pipe[2] & ~st_reg.cnv_pipe[1];
        cnv_rise = ~st_reg.cnv_pipe[2] & st_reg.cnv_pipe[1];
        cs_low = ~st_reg.cs_pipe[1];
        cs_fall = st_reg.cs_pipe[2] & ~st_reg.cs_pipe[1];
        sclk_fall = st_reg.sclk_pipe[2] & ~st_reg.sclk_pipe[1];
        done = 1'b0;
        st_next = st_reg;

        // two flops per pin, third stage only for edge finding
        st_next.cnv_pipe = {st_reg.cnv_pipe[1:0], link.conversion_start_n};
        st_next.cs_pipe = {st_reg.cs_pipe[1:0], link.chip_select_n};
        st_next.sclk_pipe = {st_reg.sclk_pipe[1:0], link.serial_clock};

        case (st_reg.mode)
            DSR_D_READY: begin
                if (cnv_fall) begin
                    st_next.samp_a = sample_a_i;
                    st_next.samp_b = sample_b_i;
                    st_next.cnt = '0;
                    st_next.busy = 1'b1;
                    st_next.mode = DSR_D_CONVERT;
                end
            end
            DSR_D_CONVERT: begin
                // conversion time from the internal oscillator, not the link clock
                if (st_reg.cnt == dsr_cnt_t'(`DSR_CONV_CYCLES - 1)) begin
                    done = 1'b1;
                    st_next.busy = 1'b0;
                    st_next.res_a = st_reg.samp_a;
                    st_next.res_b = st_reg.samp_b;
                    if (st_reg.cnv_pipe[1]) begin
                        st_next.mode = DSR_D_READY;
                    end else begin
                        st_next.mode = DSR_D_SHUTDOWN;
                        st_next.powered_down = 1'b1;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + dsr_cnt_t'(1);
                end
            end
            DSR_D_SHUTDOWN: begin
                // results stay readable; only a start rise wakes the part
                if (cnv_rise) begin
                    st_next.mode = DSR_D_READY;
                    st_next.powered_down = 1'b0;
                end
            end
            default: begin
                st_next.mode = DSR_D_READY;
            end
        endcase

        // ************
        // serial readout
        // ************

        st_next.oe = cs_low;

        if (done && cs_low) begin
            // select already low: MSB of fresh results at busy fall
            st_next.sr_first = dsr_build_frame(st_reg.samp_a, st_reg.samp_b);
            st_next.sr_second = dsr_build_frame(st_reg.samp_b, st_reg.samp_a);
        end else if (cs_fall) begin
            st_next.sr_first = dsr_build_frame(st_reg.res_a, st_reg.res_b);
            st_next.sr_second = dsr_build_frame(st_reg.res_b, st_reg.res_a);
        end else if (sclk_fall && cs_low) begin
            // a fall in the cycle of the select fall never gets here
            st_next.sr_first = st_reg.sr_first << 1;
            st_next.sr_second = st_reg.sr_second << 1;
        end
    end

    // ************
    // state register
    // ************

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= DSR_DEV_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************
    // outputs
    // ************

    assign link.busy = st_reg.busy;
    assign link.result_out_first = st_reg.sr_first[`DSR_FRAME_BITS-1];
    assign link.result_out_first_oe = st_reg.oe;
    assign link.result_out_second = st_reg.sr_second[`DSR_FRAME_BITS-1];
    assign link.result_out_second_oe = st_reg.oe;
    assign powered_down_o = st_reg.powered_down;

endmodule : dsr_device

`default_nettype wire

// ### hdl/dsr_host.sv
// dual result serial readout: host end and its result fifo
// assumes link inputs are asynchronous to clk_i; user side runs on clk_i
`timescale 1ns/1ps
`default_nettype none

module dsr_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic valid;
        logic [WIDTH-1:0] head;
    } dsr_fifo_regs_t;

    dsr_fifo_regs_t st_reg;
    dsr_fifo_regs_t st_next;

    always_comb begin
        logic push;
        logic pop;
        push = in_valid_i && (st_reg.count != (AW + 1)'(DEPTH));
        pop = out_valid_o && out_ready_i;
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data_i;
            st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + AW'(1);
        end
        if (pop) begin
            st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + AW'(1);
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + (AW + 1)'(1);
        end else if (pop && !push) begin
            st_next.count = st_reg.count - (AW + 1)'(1);
        end
        st_next.valid = st_next.count != '0;
        st_next.head = st_next.mem[st_next.rd];
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready_o = st_reg.count != (AW + 1)'(DEPTH);
    assign out_valid_o = st_reg.valid;
    assign out_data_o = st_reg.head;
endmodule : dsr_fifo

module dsr_host
    import dsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    dsr_link_if.host link,
    input wire logic start_i,
    input wire logic shutdown_i,
    input wire logic single_line_i,
    input wire logic line_sel_i,
    output logic idle_o,
    output logic result_valid_o,
    input wire logic result_ready_i,
    output logic [`DSR_RES_BITS-1:0] result_data_o,
    output logic result_chan_o
);
    // ************
    // state
    // ************

    localparam dsr_host_regs_t DSR_HOST_RESET = '{
        state: DSR_H_IDLE,
        conversion_start_n_n: 1'b1,
        cs_n: 1'b1,
        sclk: 1'b1,
        busy_pipe: `DSR_SYNC_LOW,
        first_pipe: `DSR_SYNC_LOW,
        second_pipe: `DSR_SYNC_LOW,
        busy_seen: 1'b0,
        sd: 1'b0,
        single: 1'b0,
        line: 1'b0,
        idle: 1'b0,
        cnt: '0,
        pwr: dsr_cnt_t'(`DSR_POWERUP_CYCLES),
        bits: '0,
        acc_first: '0,
        acc_second: '0
    };

    dsr_host_regs_t st_reg;
    dsr_host_regs_t st_next;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [`DSR_RES_BITS:0] fifo_in_data;
    logic [`DSR_RES_BITS:0] fifo_out_data;

    // ************
    // next state
    // ************

    always_comb begin
        dsr_frame_t acc;
        dsr_bit_t total;
        acc = st_reg.line ? st_reg.acc_second : st_reg.acc_first;
        total = st_reg.single ? dsr_bit_t'(`DSR_FRAME_BITS) : dsr_bit_t'(`DSR_RES_BITS);
        st_next = st_reg;
        st_next.busy_pipe = {st_reg.busy_pipe[0], link.busy};
        st_next.first_pipe = {st_reg.first_pipe[0], link.result_out_first};
        st_next.second_pipe = {st_reg.second_pipe[0], link.result_out_second};
        if (st_reg.pwr != '0 && st_reg.conversion_start_n_n) begin
            st_next.pwr = st_reg.pwr - dsr_cnt_t'(1);
        end

        case (st_reg.state)
            DSR_H_IDLE: begin
                st_next.idle = st_reg.pwr == '0;
                if (start_i && st_reg.pwr == '0) begin
                    st_next.conversion_start_n_n = 1'b0;
                    st_next.cnt = '0;
                    st_next.sd = shutdown_i;
                    st_next.single = single_line_i;
                    st_next.line = line_sel_i;
                    st_next.busy_seen = 1'b0;
                    st_next.idle = 1'b0;
                    st_next.state = DSR_H_CONV;
                end
            end
            DSR_H_CONV: begin
                if (st_reg.cnt != dsr_cnt_t'(`DSR_START_LOW_CYCLES - 1)) begin
                    st_next.cnt = st_reg.cnt + dsr_cnt_t'(1);
                end else if (!st_reg.sd) begin
                    st_next.conversion_start_n_n = 1'b1;
                end
                if (st_reg.busy_pipe[1]) begin
                    st_next.busy_seen = 1'b1;
                end
                if (st_reg.busy_seen && !st_reg.busy_pipe[1]) begin
                    if (st_reg.sd) begin
                        st_next.conversion_start_n_n = 1'b1;
                        st_next.pwr = dsr_cnt_t'(`DSR_POWERUP_CYCLES);
                    end
                    st_next.cs_n = 1'b0;
                    st_next.cnt = '0;
                    st_next.bits = '0;
                    st_next.state = DSR_H_READ;
                end
            end
            DSR_H_READ: begin
                st_next.cnt = st_reg.cnt + dsr_cnt_t'(1);
                if (st_reg.cnt == dsr_cnt_t'(`DSR_SCLK_HALF_CYCLES - 1)) begin
                    st_next.sclk = 1'b0;
                end
                // synchronised line at this count shows the pin at the fall
                if (st_reg.cnt == dsr_cnt_t'(`DSR_SCLK_HALF_CYCLES + `DSR_SAMPLE_DELAY_CYCLES)) begin
                    st_next.acc_first = {st_reg.acc_first[`DSR_FRAME_BITS-2:0], st_reg.first_pipe[1]};
                    st_next.acc_second = {st_reg.acc_second[`DSR_FRAME_BITS-2:0], st_reg.second_pipe[1]};
                    st_next.bits = st_reg.bits + dsr_bit_t'(1);
                end
                if (st_reg.cnt == dsr_cnt_t'(2 * `DSR_SCLK_HALF_CYCLES - 1)) begin
                    st_next.sclk = 1'b1;
                    st_next.cnt = '0;
                    if (st_reg.bits == total) begin
                        st_next.state = DSR_H_PUSH_A;
                    end
                end
            end
            DSR_H_PUSH_A: begin
                if (fifo_in_ready) begin
                    st_next.state = DSR_H_PUSH_B;
                end
            end
            DSR_H_PUSH_B: begin
                if (fifo_in_ready) begin
                    st_next.cs_n = 1'b1;
                    st_next.state = DSR_H_IDLE;
                end
            end
            default: begin
                st_next.state = DSR_H_IDLE;
            end
        endcase

        // ************
        // result words: channel bit above the data
        // ************

        fifo_in_valid = (st_reg.state == DSR_H_PUSH_A) || (st_reg.state == DSR_H_PUSH_B);
        if (st_reg.single) begin
            // combined frame: lead result, then the other one in the lower slot
            if (st_reg.state == DSR_H_PUSH_A) begin
                fifo_in_data = {st_reg.line, acc[`DSR_FRAME_BITS-1:`DSR_SLOT_BITS]};
            end else begin
                fifo_in_data = {~st_reg.line, acc[`DSR_RES_BITS-1:0]};
            end
        end else if (st_reg.state == DSR_H_PUSH_A) begin
            fifo_in_data = {1'b0, st_reg.acc_first[`DSR_RES_BITS-1:0]};
        end else begin
            fifo_in_data = {1'b1, st_reg.acc_second[`DSR_RES_BITS-1:0]};
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= DSR_HOST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************
    // result buffer and outputs
    // ************

    dsr_fifo #(
        .WIDTH(`DSR_RES_BITS + 1),
        .DEPTH(`DSR_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(result_valid_o),
        .out_ready_i(result_ready_i),
        .out_data_o(fifo_out_data)
    );

    assign result_data_o = fifo_out_data[`DSR_RES_BITS-1:0];
    assign result_chan_o = fifo_out_data[`DSR_RES_BITS];
    assign idle_o = st_reg.idle;
    assign link.conversion_start_n = st_reg.conversion_start_n_n;
    assign link.chip_select_n = st_reg.cs_n;
    assign link.serial_clock = st_reg.sclk;

endmodule : dsr_host

`default_nettype wire

// ### bench/dsr_link_properties.sv
// dual result serial readout: timing assertions on the link pins
// assumes both ends share clk_i and reset_n_i; link pins arrive as plain inputs
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.svh"

module dsr_link_properties (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic conversion_start_n,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic busy,
    input wire logic result_out_first,
    input wire logic result_out_first_oe,
    input wire logic result_out_second,
    input wire logic result_out_second_oe
);
    // ************
    // history of the pins
    // ************
    logic [7:0] busy_cnt_reg;
    logic [3:0] sclk_hist_reg;
    logic [3:0] cs_hist_reg;
    logic data_cause;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_cnt_reg <= 8'h00;
            sclk_hist_reg <= 4'hf;
            cs_hist_reg <= 4'hf;
        end else begin
            busy_cnt_reg <= busy ? busy_cnt_reg + 8'h01 : 8'h00;
            sclk_hist_reg <= {sclk_hist_reg[2:0], serial_clock};
            cs_hist_reg <= {cs_hist_reg[2:0], chip_select_n};
        end
    end
    // a clock or select fall seen three samples back
    assign data_cause = (sclk_hist_reg[3:2] == 2'h2) || (cs_hist_reg[3:2] == 2'h2);

    // ************
    // properties
    // ************
    sequence s_sclk_low;
        (!serial_clock) [*4] ##1 serial_clock;
    endsequence
    sequence s_released;
        ##3 (!result_out_first_oe && !result_out_second_oe);
    endsequence

    a_start_busy: assert property ($fell(conversion_start_n) && !busy |-> ##3 busy)
        else $error("busy late after start fall");
    a_busy_cause: assert property ($rose(busy) |-> !$past(conversion_start_n, 3))
        else $error("busy rose without start");
    a_busy_width: assert property ($fell(busy) |-> busy_cnt_reg == `DSR_CONV_CYCLES)
        else $error("busy width wrong");
    a_select_after_busy: assert property ($fell(chip_select_n) |-> !busy)
        else $error("select fell during busy");
    a_oe_driven: assert property ($fell(chip_select_n) |-> ##3 (result_out_first_oe
        && result_out_second_oe))
        else $error("outputs not driven after select fall");
    a_oe_released: assert property ($rose(chip_select_n) |-> s_released)
        else $error("outputs not released after select rise");
    a_oe_follows_select: assert property (result_out_first_oe == !$past(chip_select_n, 3)
        && result_out_second_oe == !$past(chip_select_n, 3))
        else $error("output enables off select");
    a_data_cause: assert property (result_out_first_oe && $past(result_out_first_oe)
        && ($changed(result_out_first) || $changed(result_out_second))
        |-> data_cause || $fell(busy))
        else $error("data moved without clock fall");
    a_sclk_shape: assert property ($fell(serial_clock) |-> s_sclk_low)
        else $error("serial clock low phase wrong");
    a_sclk_framed: assert property ($fell(serial_clock) |-> !chip_select_n)
        else $error("serial clock fell outside frame");
endmodule : dsr_link_properties

`default_nettype wire

// ### bench/test_dual_adc_serial_readout.sv
// dual result serial readout: converter end facing host end over the link
// assumes hdl/ header, package, interface and both ends are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.svh"

module test_dual_adc_serial_readout
    import dsr_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0;
    logic shutdown_i = 1'b0;
    logic single_line_i = 1'b0;
    logic line_sel_i = 1'b0;
    logic result_ready_i = 1'b0;
    dsr_res_t sample_a_i = '0;
    dsr_res_t sample_b_i = '0;
    logic idle_o, result_valid_o, result_chan_o, powered_down_o;
    dsr_res_t result_data_o, exp_a, exp_b;
    logic [`DSR_RES_BITS:0] exp_q[$];
    dsr_frame_t cap_first, cap_second;
    logic sclk_prev = 1'b1;
    logic pd_seen = 1'b0;
    int exp_n, falls;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    dsr_link_if link ();
    dsr_device u_dsr_device (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link.device),
        .sample_a_i(sample_a_i), .sample_b_i(sample_b_i), .powered_down_o(powered_down_o));
    dsr_host u_dsr_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link.host),
        .start_i(start_i), .shutdown_i(shutdown_i), .single_line_i(single_line_i),
        .line_sel_i(line_sel_i), .idle_o(idle_o), .result_valid_o(result_valid_o),
        .result_ready_i(result_ready_i), .result_data_o(result_data_o),
        .result_chan_o(result_chan_o));
    dsr_link_properties u_dsr_link_properties (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .conversion_start_n(link.conversion_start_n), .chip_select_n(link.chip_select_n),
        .serial_clock(link.serial_clock), .busy(link.busy),
        .result_out_first(link.result_out_first), .result_out_first_oe(link.result_out_first_oe),
        .result_out_second(link.result_out_second),
        .result_out_second_oe(link.result_out_second_oe));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // ************
    // wire monitor and checks
    // ************
    // both lines are shifted in at each clock fall inside a frame
    always @(negedge clk_i) begin
        if (link.serial_clock === 1'b0 && sclk_prev === 1'b1 && link.chip_select_n === 1'b0) begin
            cap_first = {cap_first[`DSR_FRAME_BITS-2:0], link.result_out_first};
            cap_second = {cap_second[`DSR_FRAME_BITS-2:0], link.result_out_second};
            falls++;
        end
        if (powered_down_o === 1'b1) pd_seen = 1'b1;
        sclk_prev = link.serial_clock;
    end

    function automatic dsr_frame_t exp_frame(input dsr_res_t lead, input dsr_res_t other,
        input int n);
        dsr_frame_t f;
        f = {lead, {`DSR_SLOT_BITS{1'b0}}} | dsr_frame_t'(other);
        return f >> (`DSR_FRAME_BITS - n);
    endfunction : exp_frame

    task automatic bad(input string what);
        err_count++;
        $display("BAD %0t %s", $time, what);
    endtask : bad

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) bad(what);
    endtask : cmp_val

    task automatic cmp_frame(input dsr_frame_t got, input dsr_frame_t exp, input string what);
        compares++;
        if (got !== exp) bad(what);
    endtask : cmp_frame

    task automatic cmp_word(input logic [`DSR_RES_BITS:0] got, input logic [`DSR_RES_BITS:0] exp);
        compares++;
        if (got !== exp) bad("fifo word");
    endtask : cmp_word

    task automatic wait_idle();
        repeat (4000) begin
            @(negedge clk_i);
            if (idle_o === 1'b1) break;
        end
    endtask : wait_idle

    task automatic run_txn(input logic sd, input logic single, input logic line,
        input dsr_res_t a, input dsr_res_t b);
        wait_idle();
        exp_a = a;
        exp_b = b;
        exp_n = single ? `DSR_FRAME_BITS : `DSR_RES_BITS;
        exp_q.push_back((single && line) ? {1'b1, b} : {1'b0, a});
        exp_q.push_back((single && line) ? {1'b0, a} : {1'b1, b});
        falls = 0;
        pd_seen = 1'b0;
        cap_first = '0;
        cap_second = '0;
        @(posedge clk_i);
        start_i <= 1'b1;
        shutdown_i <= sd;
        single_line_i <= single;
        line_sel_i <= line;
        sample_a_i <= a;
        sample_b_i <= b;
        @(posedge clk_i);
        start_i <= 1'b0;
    endtask : run_txn

    task automatic check_frame();
        wait_idle();
        cmp_val(falls, exp_n, "clock fall count");
        cmp_val(pd_seen, shutdown_i, "power down");
        cmp_frame(cap_first, exp_frame(exp_a, exp_b, exp_n), "first line");
        cmp_frame(cap_second, exp_frame(exp_b, exp_a, exp_n), "second line");
    endtask : check_frame

    task automatic drain(input int n);
        int got;
        got = 0;
        while (got < n) begin
            @(posedge clk_i);
            result_ready_i <= 1'($urandom);
            @(negedge clk_i);
            if (result_valid_o === 1'b1 && result_ready_i === 1'b1) begin
                cmp_word({result_chan_o, result_data_o}, exp_q.pop_front());
                got++;
            end
        end
        @(posedge clk_i);
        result_ready_i <= 1'b0;
    endtask : drain

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            bad("timeout");
            test_done();
        end
    end

    // ************
    // main sequence
    // ************
    initial begin
        void'($urandom(82));
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        run_txn(1'b0, 1'b1, 1'b0, '1, '0);
        check_frame();
        drain(2);
        for (int m = 0; m < 6; m++) begin
            run_txn(1'b0, m > 1, m > 3, dsr_res_t'($urandom), dsr_res_t'($urandom));
            check_frame();
            drain(2);
        end
        $display("test modes done");
        // shutdown read, then a normal read after wake-up
        run_txn(1'b1, 1'b0, 1'b0, dsr_res_t'($urandom), dsr_res_t'($urandom));
        check_frame();
        drain(2);
        run_txn(1'b0, 1'b1, 1'b1, dsr_res_t'($urandom), dsr_res_t'($urandom));
        check_frame();
        drain(2);
        $display("test shutdown done");
        for (int k = 0; k < 4; k++) begin
            run_txn(1'b0, 1'($urandom), 1'($urandom), dsr_res_t'($urandom), dsr_res_t'($urandom));
            check_frame();
        end
        run_txn(1'b0, 1'b0, 1'b0, dsr_res_t'($urandom), '1);
        repeat (600) @(negedge clk_i);
        cmp_val(idle_o, 1'b0, "host idle with full fifo");
        cmp_val(link.chip_select_n, 1'b0, "select released with full fifo");
        drain(10);
        check_frame();
        $display("test fifo full done");
        test_done();
    end
endmodule : test_dual_adc_serial_readout

`default_nettype wire
